// ---- verilog/dlwm_map.svh ----
// register map, field positions, reset values of the limit warning monitor
`ifndef DLWM_MAP_SVH
`define DLWM_MAP_SVH

// ------------------------------------------------------------------
// widths and counts
// ------------------------------------------------------------------
`define DLWM_AW 8
`define DLWM_DW 32
`define DLWM_NQ 4
`define DLWM_NLIM 8
`define DLWM_NFLAG 9
`define DLWM_NOUT 4
`define DLWM_SELW 4
`define DLWM_SEL_NONE 4'h9

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define DLWM_OFF_CTRL 8'h00
`define DLWM_OFF_STATE 8'h04
`define DLWM_OFF_IRQ_STAT 8'h08
`define DLWM_OFF_IRQ_MASK 8'h0c
`define DLWM_OFF_ROUTE 8'h10
`define DLWM_OFF_LIM_BASE 8'h20
`define DLWM_OFF_LIM_LAST 8'h3c
`define DLWM_LIM_IDX_HI 4
`define DLWM_LIM_IDX_LO 2

// ------------------------------------------------------------------
// fields
// ------------------------------------------------------------------
`define DLWM_CTRL_W 3
`define DLWM_CTRL_CLOSED 0
`define DLWM_CTRL_REMOTE 1
`define DLWM_CTRL_NLTRIP 2
`define DLWM_CTRL_TRIPCLR 3
`define DLWM_LIM_CUR_LO 0
`define DLWM_LIM_CUR_HI 1
`define DLWM_LIM_FREQ_LO 2
`define DLWM_LIM_FREQ_HI 3
`define DLWM_LIM_REF_LO 4
`define DLWM_LIM_REF_HI 5
`define DLWM_LIM_FB_LO 6
`define DLWM_LIM_FB_HI 7
`define DLWM_Q_CUR 0
`define DLWM_Q_FREQ 1
`define DLWM_Q_REF 2
`define DLWM_Q_FB 3

// ------------------------------------------------------------------
// reset values (limits in thousandths of the unit)
// ------------------------------------------------------------------
`define DLWM_RST_CTRL 3'h2
`define DLWM_RST_ROUTE 16'hffff
`define DLWM_RST_RANGE_MIN 32'hc4653601
`define DLWM_RST_RANGE_MAX 32'h3b9ac9ff
`define DLWM_RST_FREQ_HI 32'h0001d4c0
`define DLWM_RST_CUR_HI 32'h7fffffff
`define DLWM_RST_ZERO 32'h00000000

`endif

// ---- verilog/dlwm_pkg.sv ----
// types shared by the limit warning monitor
`include "dlwm_map.svh"
package dlwm_pkg;

    typedef enum logic [1:0] {
        DLWM_STOPPED,
        DLWM_RAMP_UP,
        DLWM_ACTIVE,
        DLWM_RAMP_DOWN
    } dlwm_phase_t;

    typedef struct packed {
        dlwm_phase_t                           phase;
        logic [`DLWM_CTRL_W-1:0]               ctrl;
        logic [`DLWM_NOUT*`DLWM_SELW-1:0]      route;
        logic [`DLWM_NFLAG-1:0]                mask;
        logic [`DLWM_NFLAG-1:0]                status;
        logic [`DLWM_NFLAG-1:0]                rd_clr;
        logic [`DLWM_NLIM-1:0][`DLWM_DW-1:0]   lim;
        logic [`DLWM_NLIM-1:0]                 warn;
        logic                                  trip;
        logic [`DLWM_NOUT-1:0]                 sig;
        logic                                  irq;
        logic                                  pready;
        logic                                  pslverr;
        logic [`DLWM_DW-1:0]                   prdata;
    } dlwm_state_t;

endpackage

// ---- verilog/dlwm_window.sv ----
// signed window comparator for one measured quantity
`timescale 1ns/1ps
`default_nettype none
`include "dlwm_map.svh"
module dlwm_window
    import dlwm_pkg::*;
(
    input  wire logic [`DLWM_DW-1:0] lo_val_in,
    input  wire logic [`DLWM_DW-1:0] hi_val_in,
    input  wire logic [`DLWM_DW-1:0] lo_lim_in,
    input  wire logic [`DLWM_DW-1:0] hi_lim_in,
    output logic                     below_out,
    output logic                     above_out
);
    assign below_out = $signed(lo_val_in) < $signed(lo_lim_in);
    assign above_out = $signed(hi_val_in) > $signed(hi_lim_in);
endmodule
`default_nettype wire

// ---- verilog/dlwm_route.sv ----
// source selection of warning flags onto signal and relay outputs
`timescale 1ns/1ps
`default_nettype none
`include "dlwm_map.svh"
module dlwm_route
    import dlwm_pkg::*;
(
    input  wire logic [`DLWM_NFLAG-1:0]             flags_in,
    input  wire logic [`DLWM_NOUT*`DLWM_SELW-1:0]   sel_in,
    output logic      [`DLWM_NOUT-1:0]              sig_out
);
    genvar g;
    generate
        for (g = 0; g < `DLWM_NOUT; g++) begin : g_out
            logic [`DLWM_SELW-1:0] sel;
            assign sel = sel_in[g*`DLWM_SELW +: `DLWM_SELW];
            // codes past the last flag switch the output off
            assign sig_out[g] = (sel < `DLWM_SEL_NONE) ? flags_in[sel] : 1'b0;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verilog/dlwm_monitor.sv ----
// limit warning monitor of a motor drive, with apb register access
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dlwm_map.svh"
module dlwm_monitor
    import dlwm_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                resetn_in,
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [`DLWM_AW-1:0] paddr_in,
    input  wire logic [`DLWM_DW-1:0] pwdata_in,
    output logic      [`DLWM_DW-1:0] prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    input  wire logic                run_cmd_in,
    input  wire logic                ref_reached_in,
    input  wire logic                motor_stopped_in,
    input  wire logic [`DLWM_DW-1:0] motor_current_in,
    input  wire logic [`DLWM_DW-1:0] out_freq_in,
    input  wire logic [`DLWM_DW-1:0] remote_ref_hz_in,
    input  wire logic [`DLWM_DW-1:0] remote_ref_pu_in,
    input  wire logic [`DLWM_DW-1:0] result_ref_hz_in,
    input  wire logic [`DLWM_DW-1:0] result_ref_pu_in,
    input  wire logic [`DLWM_DW-1:0] feedback_in,
    output logic                     warn_current_below_out,
    output logic                     warn_current_above_out,
    output logic                     warn_freq_below_out,
    output logic                     warn_freq_above_out,
    output logic                     warn_ref_below_out,
    output logic                     warn_ref_above_out,
    output logic                     warn_feedback_below_out,
    output logic                     warn_feedback_above_out,
    output logic                     trip_out,
    output logic      [1:0]          digital_sig_out,
    output logic      [1:0]          relay_out,
    output logic                     irq_out
);

    // ------------------------------------------------------------------
    // state and comparators
    // ------------------------------------------------------------------
    dlwm_state_t                          s_q;
    dlwm_state_t                          s_d;
    logic [`DLWM_NQ-1:0][`DLWM_DW-1:0]    val_lo;
    logic [`DLWM_NQ-1:0][`DLWM_DW-1:0]    val_hi;
    logic [`DLWM_NLIM-1:0]                raw;
    logic [`DLWM_NOUT-1:0]                route_sig;
    logic                                 closed;
    logic                                 remote;
    logic                                 nltrip;

    assign closed = s_q.ctrl[`DLWM_CTRL_CLOSED];
    assign remote = s_q.ctrl[`DLWM_CTRL_REMOTE];
    assign nltrip = s_q.ctrl[`DLWM_CTRL_NLTRIP];

    assign val_lo[`DLWM_Q_CUR]  = motor_current_in;
    assign val_hi[`DLWM_Q_CUR]  = motor_current_in;
    assign val_lo[`DLWM_Q_FREQ] = out_freq_in;
    assign val_hi[`DLWM_Q_FREQ] = out_freq_in;
    // low limit watches the remote reference, high the resulting one
    assign val_lo[`DLWM_Q_REF]  = closed ? remote_ref_pu_in
                                         : remote_ref_hz_in;
    assign val_hi[`DLWM_Q_REF]  = closed ? result_ref_pu_in
                                         : result_ref_hz_in;
    assign val_lo[`DLWM_Q_FB]   = feedback_in;
    assign val_hi[`DLWM_Q_FB]   = feedback_in;

    genvar g;
    generate
        for (g = 0; g < `DLWM_NQ; g++) begin : g_win
            dlwm_window u_win (
                .lo_val_in (val_lo[g]),
                .hi_val_in (val_hi[g]),
                .lo_lim_in (s_q.lim[2*g]),
                .hi_lim_in (s_q.lim[2*g+1]),
                .below_out (raw[2*g]),
                .above_out (raw[2*g+1])
            );
        end
    endgenerate

    // route works from registered flags, so outputs lag them by a cycle
    dlwm_route u_route (
        .flags_in ({s_q.trip, s_q.warn}),
        .sel_in   (s_q.route),
        .sig_out  (route_sig)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic                        armed;
        logic [`DLWM_NLIM-1:0]       en;
        logic                        setup;
        logic                        acc;
        logic                        lim_hit;
        logic [2:0]                  idx;
        logic [`DLWM_NFLAG-1:0]      set;
        logic [`DLWM_NFLAG-1:0]      clr;
        logic                        trip_set;
        logic                        trip_clr;
        armed    = 1'b0;
        en       = '0;
        setup    = 1'b0;
        acc      = 1'b0;
        lim_hit  = 1'b0;
        idx      = '0;
        set      = '0;
        clr      = '0;
        trip_set = 1'b0;
        trip_clr = 1'b0;
        s_d      = s_q;

        armed = (s_q.phase == DLWM_ACTIVE);
        case (s_q.phase)
            DLWM_STOPPED: begin
                if (run_cmd_in && !s_q.trip) begin
                    s_d.phase = DLWM_RAMP_UP;
                end
            end
            DLWM_RAMP_UP: begin
                if (!run_cmd_in) begin
                    s_d.phase = DLWM_RAMP_DOWN;
                end else if (ref_reached_in) begin
                    s_d.phase = DLWM_ACTIVE;
                end
            end
            DLWM_ACTIVE: begin
                if (!run_cmd_in) begin
                    s_d.phase = DLWM_RAMP_DOWN;
                end
            end
            DLWM_RAMP_DOWN: begin
                if (run_cmd_in) begin
                    s_d.phase = DLWM_RAMP_UP;
                end else if (motor_stopped_in) begin
                    s_d.phase = DLWM_STOPPED;
                end
            end
            default: begin
                s_d.phase = DLWM_STOPPED;
            end
        endcase
        // a latched trip forces the stopped phase on the next clock
        if (s_q.trip) begin
            s_d.phase = DLWM_STOPPED;
        end

        // warnings only in the active phase
        en = {`DLWM_NLIM{armed}};
        en[`DLWM_LIM_REF_LO] = armed && remote;
        en[`DLWM_LIM_REF_HI] = armed && remote;
        en[`DLWM_LIM_CUR_LO] = armed && !nltrip;
        s_d.warn = raw & en;

        trip_set = armed && nltrip && raw[`DLWM_LIM_CUR_LO];

        // apb: registered answer, one access cycle, no wait states
        setup = psel_in && !penable_in && !s_q.pready;
        acc   = psel_in && penable_in && s_q.pready;
        lim_hit = (paddr_in >= `DLWM_OFF_LIM_BASE)
               && (paddr_in <= `DLWM_OFF_LIM_LAST)
               && (paddr_in[1:0] == 2'h0);
        idx = paddr_in[`DLWM_LIM_IDX_HI:`DLWM_LIM_IDX_LO];
        s_d.pready = setup;
        if (setup) begin
            s_d.prdata  = '0;
            s_d.pslverr = 1'b0;
            s_d.rd_clr  = '0;
            case (paddr_in)
                `DLWM_OFF_CTRL: begin
                    s_d.prdata[`DLWM_CTRL_W-1:0] = s_q.ctrl;
                end
                `DLWM_OFF_STATE: begin
                    s_d.prdata[`DLWM_NFLAG+1:0] =
                        {s_q.phase, s_q.trip, s_q.warn};
                end
                `DLWM_OFF_IRQ_STAT: begin
                    s_d.prdata[`DLWM_NFLAG-1:0] = s_q.status;
                    s_d.rd_clr = pwrite_in ? '0 : s_q.status;
                end
                `DLWM_OFF_IRQ_MASK: begin
                    s_d.prdata[`DLWM_NFLAG-1:0] = s_q.mask;
                end
                `DLWM_OFF_ROUTE: begin
                    s_d.prdata[`DLWM_NOUT*`DLWM_SELW-1:0] = s_q.route;
                end
                default: begin
                    if (lim_hit) begin
                        s_d.prdata = s_q.lim[idx];
                    end else begin
                        s_d.pslverr = 1'b1;
                    end
                end
            endcase
        end
        if (acc && pwrite_in && !s_q.pslverr) begin
            case (paddr_in)
                `DLWM_OFF_CTRL: begin
                    s_d.ctrl = pwdata_in[`DLWM_CTRL_W-1:0];
                    trip_clr = pwdata_in[`DLWM_CTRL_TRIPCLR];
                end
                `DLWM_OFF_IRQ_MASK: begin
                    s_d.mask = pwdata_in[`DLWM_NFLAG-1:0];
                end
                `DLWM_OFF_ROUTE: begin
                    s_d.route = pwdata_in[`DLWM_NOUT*`DLWM_SELW-1:0];
                end
                default: begin
                    if (lim_hit && !idx[0]) begin
                        // lower limit never above its partner
                        s_d.lim[idx] = ($signed(pwdata_in)
                            > $signed(s_q.lim[idx+3'h1]))
                            ? s_q.lim[idx+3'h1] : pwdata_in;
                    end else if (lim_hit) begin
                        s_d.lim[idx] = ($signed(pwdata_in)
                            < $signed(s_q.lim[idx-3'h1]))
                            ? s_q.lim[idx-3'h1] : pwdata_in;
                    end
                end
            endcase
        end

        // trip latches; a new trip wins over a clear
        s_d.trip = trip_set || (s_q.trip && !trip_clr);

        // sticky events on rising flags; set wins over read clear
        set = {s_d.trip, s_d.warn} & ~{s_q.trip, s_q.warn};
        clr = (acc && !pwrite_in) ? s_q.rd_clr : '0;
        s_d.status = (s_q.status & ~clr) | set;
        if (acc) begin
            s_d.rd_clr = '0;
        end
        s_d.irq = |(s_d.status & s_d.mask);
        s_d.sig = route_sig;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_q         <= '0;
            s_q.phase   <= DLWM_STOPPED;
            s_q.ctrl    <= `DLWM_RST_CTRL;
            s_q.route   <= `DLWM_RST_ROUTE;
            s_q.lim[`DLWM_LIM_CUR_LO]  <= `DLWM_RST_ZERO;
            s_q.lim[`DLWM_LIM_CUR_HI]  <= `DLWM_RST_CUR_HI;
            s_q.lim[`DLWM_LIM_FREQ_LO] <= `DLWM_RST_ZERO;
            s_q.lim[`DLWM_LIM_FREQ_HI] <= `DLWM_RST_FREQ_HI;
            s_q.lim[`DLWM_LIM_REF_LO]  <= `DLWM_RST_RANGE_MIN;
            s_q.lim[`DLWM_LIM_REF_HI]  <= `DLWM_RST_RANGE_MAX;
            s_q.lim[`DLWM_LIM_FB_LO]   <= `DLWM_RST_RANGE_MIN;
            s_q.lim[`DLWM_LIM_FB_HI]   <= `DLWM_RST_RANGE_MAX;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata_out              = s_q.prdata;
    assign pready_out              = s_q.pready;
    assign pslverr_out             = s_q.pslverr;
    assign warn_current_below_out  = s_q.warn[`DLWM_LIM_CUR_LO];
    assign warn_current_above_out  = s_q.warn[`DLWM_LIM_CUR_HI];
    assign warn_freq_below_out     = s_q.warn[`DLWM_LIM_FREQ_LO];
    assign warn_freq_above_out     = s_q.warn[`DLWM_LIM_FREQ_HI];
    assign warn_ref_below_out      = s_q.warn[`DLWM_LIM_REF_LO];
    assign warn_ref_above_out      = s_q.warn[`DLWM_LIM_REF_HI];
    assign warn_feedback_below_out = s_q.warn[`DLWM_LIM_FB_LO];
    assign warn_feedback_above_out = s_q.warn[`DLWM_LIM_FB_HI];
    assign trip_out                = s_q.trip;
    assign digital_sig_out         = s_q.sig[1:0];
    assign relay_out               = s_q.sig[3:2];
    assign irq_out                 = s_q.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    logic armed_q;
    assign armed_q = (s_q.phase == DLWM_ACTIVE);

    sequence s_ramp_done;
        s_q.phase == DLWM_RAMP_UP && run_cmd_in && ref_reached_in
            && !s_q.trip;
    endsequence

    sequence s_freq_over;
        armed_q && ($signed(out_freq_in)
            > $signed(s_q.lim[`DLWM_LIM_FREQ_HI]));
    endsequence

    property p_freq_above;
        s_freq_over |=> warn_freq_above_out;
    endproperty
    a_freq_above: assert property (p_freq_above)
        else $error("freq above limit without warning");

    property p_quiet_unarmed;
        !armed_q |=> (s_q.warn == '0);
    endproperty
    a_quiet_unarmed: assert property (p_quiet_unarmed)
        else $error("warning raised outside active phase");

    property p_arm;
        s_ramp_done |=> armed_q ##1 (s_q.phase != DLWM_STOPPED);
    endproperty
    a_arm: assert property (p_arm)
        else $error("monitor not armed after reaching reference");

    property p_route0;
        ($stable(s_q.route) && s_q.route[3:0] == 4'h3)
            |=> (digital_sig_out[0] == $past(s_q.warn[3]));
    endproperty
    a_route0: assert property (p_route0)
        else $error("routed output does not follow its flag");

    property p_ref_below;
        (armed_q && remote && ($signed(val_lo[`DLWM_Q_REF])
            < $signed(s_q.lim[`DLWM_LIM_REF_LO])))
            |=> warn_ref_below_out;
    endproperty
    a_ref_below: assert property (p_ref_below)
        else $error("reference below limit without warning");

    property p_ref_gate;
        !remote |=> !warn_ref_below_out && !warn_ref_above_out;
    endproperty
    a_ref_gate: assert property (p_ref_gate)
        else $error("reference warning while remote not selected");

    property p_ref_unit;
        (armed_q && remote && closed && ($signed(result_ref_pu_in)
            > $signed(s_q.lim[`DLWM_LIM_REF_HI])))
            |=> warn_ref_above_out;
    endproperty
    a_ref_unit: assert property (p_ref_unit)
        else $error("closed loop reference not compared in process unit");

    property p_fb_below;
        (armed_q && ($signed(feedback_in)
            < $signed(s_q.lim[`DLWM_LIM_FB_LO])))
            |=> warn_feedback_below_out;
    endproperty
    a_fb_below: assert property (p_fb_below)
        else $error("feedback below limit without warning");

    property p_trip;
        (armed_q && nltrip && ($signed(motor_current_in)
            < $signed(s_q.lim[`DLWM_LIM_CUR_LO])))
            |=> trip_out && !warn_current_below_out ##1 trip_out;
    endproperty
    a_trip: assert property (p_trip)
        else $error("no-load trip missing");

    // the bench crosses the frequency pair on purpose, so watch it too
    property p_clamp;
        ($signed(s_q.lim[`DLWM_LIM_FREQ_LO])
            <= $signed(s_q.lim[`DLWM_LIM_FREQ_HI]))
        && ($signed(s_q.lim[`DLWM_LIM_FB_LO])
            <= $signed(s_q.lim[`DLWM_LIM_FB_HI]));
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("lower limit above its upper limit");

    property p_drop;
        (warn_freq_above_out && ($signed(out_freq_in)
            <= $signed(s_q.lim[`DLWM_LIM_FREQ_HI])))
            |=> !warn_freq_above_out;
    endproperty
    a_drop: assert property (p_drop)
        else $error("warning held after value returned");

endmodule
`default_nettype wire

// ---- test/dlwm_drive_model.sv ----
// drive control core model: start, ramp and standstill around the monitor
`timescale 1ns/1ps
`default_nettype none
module dlwm_drive_model (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    input  wire logic start_in,
    input  wire logic slow_in,
    output logic      run_cmd_out,
    output logic      ref_reached_out,
    output logic      motor_stopped_out
);
    logic [3:0] ramp_q;
    // slow ramps one step a cycle, prompt ramps four
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ramp_q <= 4'h0;
        end else if (start_in && ramp_q != 4'hc) begin
            ramp_q <= ramp_q + (slow_in ? 4'h1 : 4'h4);
        end else if (!start_in && ramp_q != 4'h0) begin
            ramp_q <= ramp_q - (slow_in ? 4'h1 : 4'h4);
        end
    end
    assign run_cmd_out = start_in;
    assign ref_reached_out = start_in && ramp_q == 4'hc;
    assign motor_stopped_out = !start_in && ramp_q == 4'h0;
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench of the limit warning monitor
`timescale 1ns/1ps
`default_nettype none
`include "dlwm_map.svh"
module testbench
    import dlwm_pkg::*;
;
    logic        clk_in = 0, resetn_in = 0, start = 0, slow = 1;
    logic        psel = 0, pen = 0, pwr = 0, pslverr, pready, irq, trip;
    logic        run, reached, stopped;
    logic [7:0]  paddr = 0;
    wire logic [7:0] warn;
    logic [1:0]  dsig, relay;
    logic [31:0] pwdata = 0, prdata, cur = 0, freq = 0, fb = 0;
    logic [31:0] rref = 0, xref = 0, rpu = 500, xpu = 950;
    logic [32:0] expq[$];
    int          miscompares = 0, total_checks = 0, seed = 37546;
    logic [31:0] lrst [8] = '{0, 32'h7fffffff, 0, 32'h1d4c0, 32'hc4653601,
                              32'h3b9ac9ff, 32'hc4653601, 32'h3b9ac9ff};
    dlwm_drive_model i_dlwm_drive_model (.clk_in, .resetn_in,
        .start_in(start), .slow_in(slow), .run_cmd_out(run),
        .ref_reached_out(reached), .motor_stopped_out(stopped));
    dlwm_monitor i_dlwm_monitor (.clk_in, .resetn_in, .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .run_cmd_in(run), .ref_reached_in(reached),
        .motor_stopped_in(stopped), .motor_current_in(cur),
        .out_freq_in(freq), .remote_ref_hz_in(rref), .remote_ref_pu_in(rpu),
        .result_ref_hz_in(xref), .result_ref_pu_in(xpu), .feedback_in(fb),
        .warn_current_below_out(warn[0]), .warn_current_above_out(warn[1]),
        .warn_freq_below_out(warn[2]), .warn_freq_above_out(warn[3]),
        .warn_ref_below_out(warn[4]), .warn_ref_above_out(warn[5]),
        .warn_feedback_below_out(warn[6]),
        .warn_feedback_above_out(warn[7]), .trip_out(trip),
        .digital_sig_out(dsig), .relay_out(relay), .irq_out(irq));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic conclude();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(string name, logic [32:0] seen, logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        for (int n = 0; pready !== 1'b1; n++) begin
            if (n == 20) begin
                miscompares++;
                conclude();
            end
            @(posedge clk_in);
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] d, logic e = 1'b0);
        expq.push_back({e, d});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wait_reached();
        for (int n = 0; !reached; n++) begin
            if (n == 100) begin
                miscompares++;
                conclude();
            end
            @(posedge clk_in);
        end
    endtask
    // read results are compared in the order they were noted
    always @(posedge clk_in) begin
        if (psel && pen && pready === 1'b1 && !pwr && expq.size() > 0) begin
            check("read data", {pslverr, prdata}, expq.pop_front());
        end
    end
    initial begin
        hold(6);
        resetn_in <= 1'b1;
        rd(`DLWM_OFF_CTRL, 32'h2);
        rd(`DLWM_OFF_ROUTE, 32'hffff);
        rd(`DLWM_OFF_IRQ_MASK, 32'h0);
        for (int i = 0; i < 8; i++) rd(8'h20 + 8'(4 * i), lrst[i]);
        rd(8'h14, 32'h0, 1'b1);
        apb(1'b1, 8'h28, 32'h30d40);
        rd(8'h28, 32'h1d4c0);
        apb(1'b1, 8'h28, 32'h0);
        apb(1'b1, 8'h2c, 32'hffffff00);
        rd(8'h2c, 32'h0);
        apb(1'b1, 8'h2c, 32'h1d4c0);
        apb(1'b1, 8'h38, 32'd1000);
        apb(1'b1, 8'h3c, 32'd5000);
        apb(1'b1, 8'h30, 32'd100);
        apb(1'b1, 8'h34, 32'd900);
        apb(1'b1, 8'h20, 32'd500);
        apb(1'b1, `DLWM_OFF_IRQ_MASK, 32'h1ff);
        apb(1'b1, `DLWM_OFF_ROUTE, 32'hf673);
        freq <= 32'd200000;
        xref <= 32'd1000;
        fb <= 32'd999 - ($random(seed) & 32'hff);
        rd(`DLWM_OFF_STATE, 32'h0);
        start <= 1'b1;
        rd(`DLWM_OFF_STATE, 32'h200);
        wait_reached();
        rd(`DLWM_OFF_STATE, 32'h479);
        check("warn", warn, 8'h79);
        check("routed", {relay, dsig}, 4'h5);
        check("irq", irq, 1'b1);
        rd(`DLWM_OFF_IRQ_STAT, 32'h79);
        hold(2);
        check("irq", irq, 1'b0);
        apb(1'b1, `DLWM_OFF_CTRL, 32'h3);
        rd(`DLWM_OFF_STATE, 32'h469);
        apb(1'b1, `DLWM_OFF_CTRL, 32'h0);
        rd(`DLWM_OFF_STATE, 32'h449);
        fb <= 32'd3000;
        rd(`DLWM_OFF_STATE, 32'h409);
        fb <= 32'd6000 + ($random(seed) & 32'hfff);
        apb(1'b1, 8'h28, 32'd100000);
        freq <= 32'd50000;
        rd(`DLWM_OFF_STATE, 32'h485);
        check("warn", warn, 8'h85);
        cur <= 32'd2000;
        apb(1'b1, 8'h24, 32'd1000);
        rd(`DLWM_OFF_STATE, 32'h486);
        cur <= 32'd0;
        apb(1'b1, `DLWM_OFF_CTRL, 32'h4);
        hold(3);
        check("trip", {trip, warn[0]}, 2'b10);
        start <= 1'b0;
        hold(30);
        rd(`DLWM_OFF_STATE, 32'h100);
        apb(1'b1, `DLWM_OFF_CTRL, 32'h8);
        rd(`DLWM_OFF_STATE, 32'h0);
        start <= 1'b1;
        wait_reached();
        start <= 1'b0;
        hold(1);
        rd(`DLWM_OFF_STATE, 32'h600);
        hold(16);
        rd(`DLWM_OFF_STATE, 32'h0);
        hold(2);
        conclude();
    end
endmodule
`default_nettype wire
